// file: src/tls_regs.sv
// Contract
// - Second status bit 7 high during 30 ms power-up, cleared afterwards.
// - Second status bit 6 reports discrete transistor present with compensation on.
// - Second status at 33h is read-only; bits 5 to 0 read zero.
// - Remote over-temperature limit, 8-bit unsigned, at 07h or 0Dh, resets 55h.
// - Shared local limit at 20h serves both local comparisons, resets 55h.
// - Remote critical limit, 8-bit unsigned at 19h, resets 6Eh.
// - Common hysteresis at 21h, five bits, upper bits zero, resets 0Ah.
// - Maker identity at FEh is read-only and returns a fixed code.
// - Die revision at FFh is read-only, one step per silicon revision.
// - First status: remote over-temperature bit 4, critical bit 1, local bit 0.
// - Mask bits: remote over, remote critical, local over, local critical.
// - Mode select set means compensated integrated model, clear means discrete.
module tls_regs
  import tls_pkg::*;
#(
  parameter int         POWERUP_COUNT = POWERUP_CYCLES,
  parameter logic [7:0] MAKER_CODE    = 8'h5A,
  parameter logic [7:0] REVISION_CODE = 8'h10
) (
  // Core clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // Link clock and reset
  input  wire logic         linkClk,
  input  wire logic         linkRst,
  // Register access on the link clock
  input  wire logic         regStrobe,
  input  wire logic         regWrite,
  input  wire logic [7:0]   regAddr,
  input  wire logic [7:0]   regWrData,
  output logic              regBusy,
  output logic              regDone,
  output logic [7:0]        regRdData,
  // Conversion core
  input  wire logic         tempValid,
  input  wire logic [7:0]   remoteTemp,
  input  wire logic [7:0]   localTemp,
  input  wire logic         discreteDetect,
  input  wire logic         diodeModeSelect,
  input  wire tls_mask_type channelMask,
  // Alarm pins
  output logic              criticalAlarmOutput_n,
  output logic              overtempShutdownOutput_n
);

  // ***************************************************************
  // Elaboration checks
  // ***************************************************************
  generate
    if (POWERUP_COUNT < 1) begin : g_bad_count
      $error("POWERUP_COUNT must be at least one");
    end

    if (HYST_WIDTH != 5) begin : g_bad_hyst
      $error("HYST_WIDTH must be five to fit the zero-padded read");
    end
  endgenerate

  // ***************************************************************
  // Address decode
  // ***************************************************************
  // The remote over-temperature limit answers at two addresses.
  function automatic logic isRemoteOt(input logic [7:0] a);
    return (a == ADDR_REMOTE_OT_A) || (a == ADDR_REMOTE_OT_B);
  endfunction

  // Only the four limit registers accept writes; all else is read-only.
  function automatic logic isWritable(input logic [7:0] a);
    return isRemoteOt(a) || (a == ADDR_REMOTE_CRIT) ||
           (a == ADDR_LOCAL_SHARED) || (a == ADDR_HYSTERESIS);
  endfunction

  // ***************************************************************
  // Link side: capture a request and wait for its answer
  // ***************************************************************
  tls_req_type linkReq_r;
  logic        reqTgl_r;
  logic        ackSeen_r;
  logic        regDone_r;
  logic [7:0]  regRdData_r;
  logic        ackSync;
  logic [7:0]  rdHold_r;
  logic        ackTgl_r;

  wire linkPending = (reqTgl_r != ackSeen_r);
  wire linkTake    = regStrobe && !linkPending;
  wire linkAnswer  = (ackSync != ackSeen_r);

  tls_sync #(
    .WIDTH   (1)
  ) u_ack_sync (
    .clk     (linkClk),
    .rst     (linkRst),
    .asyncIn (ackTgl_r),
    .syncOut (ackSync)
  );

  // Requests cross to the core clock as a toggle, and answers come back the
  // same way. The request word itself is not synchronised; it is safe because
  // it is held from the take until the answer returns, long after the core
  // has sampled it. The price is a round trip of several cycles on each side.
  // A request made while one is pending is dropped; regBusy warns of it.
  // The host must wait for regDone before it strobes again.
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      linkReq_r <= '0;
      reqTgl_r  <= 1'b0;
    end else if (linkTake) begin
      linkReq_r <= '{addr: regAddr, data: regWrData, write: regWrite};
      reqTgl_r  <= ~reqTgl_r;
    end
  end

  // The answer word is stable in the core domain until the next request.
  // The done pulse lasts one cycle because ackSeen_r catches up on its edge.
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      ackSeen_r   <= 1'b0;
      regDone_r   <= 1'b0;
      regRdData_r <= 8'h00;
    end else begin
      regDone_r <= linkAnswer;
      if (linkAnswer) begin
        ackSeen_r   <= ackSync;
        regRdData_r <= rdHold_r;
      end
    end
  end

  assign regBusy   = linkPending;
  assign regDone   = regDone_r;
  assign regRdData = regRdData_r;

  // ***************************************************************
  // Core side: carry out the request
  // ***************************************************************
  logic reqSync;
  logic reqSeen_r;

  tls_sync #(
    .WIDTH   (1)
  ) u_req_sync (
    .clk     (ref_clk),
    .rst     (rst),
    .asyncIn (reqTgl_r),
    .syncOut (reqSync)
  );

  // A request is served once per toggle; coreReq lasts exactly one cycle
  // because reqSeen_r catches up on the edge that serves it.
  wire         coreReq  = (reqSync != reqSeen_r);
  tls_req_type coreWord;
  assign coreWord = linkReq_r;
  wire         coreWr   = coreReq && coreWord.write && isWritable(coreWord.addr);

  // ***************************************************************
  // Limit registers
  // ***************************************************************
  logic [7:0]            remoteOtLimit_r;
  logic [7:0]            remoteCritLimit_r;
  logic [7:0]            localLimit_r;
  logic [HYST_WIDTH-1:0] hysteresis_r;

  // Both remote over-temperature addresses land on one register, so a write
  // through either address reads back through the other.
  // Writes to read-only or unmapped addresses are dropped without notice.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      remoteOtLimit_r   <= RESET_REMOTE_OT;
      remoteCritLimit_r <= RESET_REMOTE_CRIT;
      localLimit_r      <= RESET_LOCAL_SHARED;
      hysteresis_r      <= RESET_HYSTERESIS;
    end else if (coreWr) begin
      if (isRemoteOt(coreWord.addr)) begin
        remoteOtLimit_r <= coreWord.data;
      end
      if (coreWord.addr == ADDR_REMOTE_CRIT) begin
        remoteCritLimit_r <= coreWord.data;
      end
      if (coreWord.addr == ADDR_LOCAL_SHARED) begin
        localLimit_r <= coreWord.data;
      end
      if (coreWord.addr == ADDR_HYSTERESIS) begin
        hysteresis_r <= coreWord.data[HYST_WIDTH-1:0];
      end
    end
  end

  // ***************************************************************
  // Power-up sequence
  // ***************************************************************
  // The width covers the full count, so any legal POWERUP_COUNT fits.
  localparam int PU_W = $clog2(POWERUP_COUNT + 1);
  logic [PU_W-1:0] powerupCnt_r;
  wire             notReady = (powerupCnt_r != '0);

  // The counter loads on every core reset, so a reset in mid-run restarts
  // the not-ready window and holds off comparisons again.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      powerupCnt_r <= PU_W'(POWERUP_COUNT);
    end else if (notReady) begin
      powerupCnt_r <= powerupCnt_r - 1'b1;
    end
  end

  // ***************************************************************
  // Limit comparisons
  // ***************************************************************
  logic remoteOtFlag;
  logic remoteCritFlag;
  logic localFlag;

  // Comparisons wait until the power-up sequence has finished.
  wire sampleNow  = tempValid && !notReady;
  wire localOn    = !channelMask.localOtMask || !channelMask.localCritMask;

  tls_limit_cmp u_remote_ot (
    .clk    (ref_clk),
    .rst    (rst),
    .sample (sampleNow),
    .temp   (remoteTemp),
    .limit  (remoteOtLimit_r),
    .hyst   (hysteresis_r),
    .enable (!channelMask.remoteOtMask),
    .flag   (remoteOtFlag)
  );

  tls_limit_cmp u_remote_crit (
    .clk    (ref_clk),
    .rst    (rst),
    .sample (sampleNow),
    .temp   (remoteTemp),
    .limit  (remoteCritLimit_r),
    .hyst   (hysteresis_r),
    .enable (!channelMask.remoteCritMask),
    .flag   (remoteCritFlag)
  );

  // One local limit feeds both the local critical and local shutdown paths.
  tls_limit_cmp u_local (
    .clk    (ref_clk),
    .rst    (rst),
    .sample (sampleNow),
    .temp   (localTemp),
    .limit  (localLimit_r),
    .hyst   (hysteresis_r),
    .enable (localOn),
    .flag   (localFlag)
  );

  // ***************************************************************
  // Alarm pins
  // ***************************************************************
  logic critPin_r;
  logic otPin_r;

  // The pins are registered so that they never glitch while flags and masks
  // change together. A masked channel is also kept off its pin, so a flag set
  // before the mask arrived cannot hold an alarm on.
  wire critNext = (remoteCritFlag && !channelMask.remoteCritMask) ||
                  (localFlag && !channelMask.localCritMask);
  wire otNext   = (remoteOtFlag && !channelMask.remoteOtMask) ||
                  (localFlag && !channelMask.localOtMask);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      critPin_r <= 1'b0;
      otPin_r   <= 1'b0;
    end else begin
      critPin_r <= critNext;
      otPin_r   <= otNext;
    end
  end

  assign criticalAlarmOutput_n    = !critPin_r;
  assign overtempShutdownOutput_n = !otPin_r;

  // ***************************************************************
  // Status words
  // ***************************************************************
  // The detect bit only means something when the compensated model is chosen.
  wire compensated = diodeModeSelect;
  wire discreteCompensatedFlag = discreteDetect && compensated;

  logic [7:0] firstStatus;
  logic [7:0] secondStatus;

  always_comb begin
    firstStatus                        = 8'h00;
    firstStatus[STAT1_REMOTE_OT_BIT]   = remoteOtFlag;
    firstStatus[STAT1_REMOTE_CRIT_BIT] = remoteCritFlag;
    firstStatus[STAT1_LOCAL_BIT]       = localFlag;
  end

  // Reserved bits are cleared first and only the defined bits are placed.
  always_comb begin
    secondStatus                       = 8'h00;
    secondStatus[STAT2_NOT_READY_BIT]  = notReady;
    secondStatus[STAT2_DISCRETE_BIT]   = discreteCompensatedFlag;
  end

  // ***************************************************************
  // Read selection
  // ***************************************************************
  logic [7:0] readValue;

  // The word is chosen from the held request, not the live bus, so it
  // cannot change while the core latches it.
  always_comb begin
    readValue = 8'h00;
    if (isRemoteOt(coreWord.addr)) begin
      readValue = remoteOtLimit_r;
    end else begin
      unique case (coreWord.addr)
        ADDR_FIRST_STATUS:  readValue = firstStatus;
        ADDR_REMOTE_CRIT:   readValue = remoteCritLimit_r;
        ADDR_LOCAL_SHARED:  readValue = localLimit_r;
        ADDR_HYSTERESIS:    readValue = {3'h0, hysteresis_r};
        ADDR_SECOND_STATUS: readValue = secondStatus;
        ADDR_MAKER_ID:      readValue = MAKER_CODE;
        ADDR_DIE_REVISION:  readValue = REVISION_CODE;
        default:            readValue = 8'h00;
      endcase
    end
  end

  // The answer is latched on the same edge that toggles the acknowledge, so the link
  // side never sees the word change while it samples it.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reqSeen_r <= 1'b0;
      ackTgl_r  <= 1'b0;
      rdHold_r  <= 8'h00;
    end else if (coreReq) begin
      reqSeen_r <= reqSync;
      ackTgl_r  <= ~ackTgl_r;
      rdHold_r  <= readValue;
    end
  end

endmodule

// file: src/tls_pkg.sv
package tls_pkg;

  // ***************************************************************
  // Register offsets
  // ***************************************************************
  localparam logic [7:0] ADDR_FIRST_STATUS   = 8'h02;
  localparam logic [7:0] ADDR_REMOTE_OT_A    = 8'h07;
  localparam logic [7:0] ADDR_REMOTE_OT_B    = 8'h0D;
  localparam logic [7:0] ADDR_REMOTE_CRIT    = 8'h19;
  localparam logic [7:0] ADDR_LOCAL_SHARED   = 8'h20;
  localparam logic [7:0] ADDR_HYSTERESIS     = 8'h21;
  localparam logic [7:0] ADDR_SECOND_STATUS  = 8'h33;
  localparam logic [7:0] ADDR_MAKER_ID       = 8'hFE;
  localparam logic [7:0] ADDR_DIE_REVISION   = 8'hFF;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] RESET_REMOTE_OT     = 8'h55;
  localparam logic [7:0] RESET_REMOTE_CRIT   = 8'h6E;
  localparam logic [7:0] RESET_LOCAL_SHARED  = 8'h55;
  localparam logic [4:0] RESET_HYSTERESIS    = 5'h0A;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int STAT2_NOT_READY_BIT   = 7;
  localparam int STAT2_DISCRETE_BIT    = 6;
  localparam int STAT1_REMOTE_OT_BIT   = 4;
  localparam int STAT1_REMOTE_CRIT_BIT = 1;
  localparam int STAT1_LOCAL_BIT       = 0;
  localparam int HYST_WIDTH            = 5;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int REF_CLK_KHZ        = 10000;
  localparam int POWERUP_TIME_MS    = 30;
  localparam int POWERUP_CYCLES     = POWERUP_TIME_MS * REF_CLK_KHZ;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic       write;
  } tls_req_type;

  typedef struct packed {
    logic remoteOtMask;
    logic remoteCritMask;
    logic localOtMask;
    logic localCritMask;
  } tls_mask_type;

endpackage

// file: src/tls_sync.sv
module tls_sync
  import tls_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] held_r;
  wire              agree = (stage2_r == stage3_r);

  // A change is only taken once the last two stages agree.
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
      stage3_r <= '0;
      held_r   <= '0;
    end else begin
      stage1_r <= asyncIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      if (agree) begin
        held_r <= stage3_r;
      end
    end
  end

  assign syncOut = held_r;

endmodule

// file: src/tls_limit_cmp.sv
module tls_limit_cmp
  import tls_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Comparison inputs
  input  wire logic                  sample,
  input  wire logic [7:0]            temp,
  input  wire logic [7:0]            limit,
  input  wire logic [HYST_WIDTH-1:0] hyst,
  input  wire logic                  enable,
  // Result
  output logic                       flag
);

  logic       flag_r;
  wire  [7:0] hyst8     = {3'h0, hyst};
  wire        underflow = (limit < hyst8);
  wire  [7:0] clearLvl  = underflow ? 8'h00 : (limit - hyst8);
  wire        above     = (temp > limit);
  wire        below     = !underflow && (temp < clearLvl);

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (sample) begin
      if (above && enable) begin
        flag_r <= 1'b1;
      end else if (below) begin
        flag_r <= 1'b0;
      end
    end
  end

  assign flag = flag_r;

endmodule

// file: testbench/tls_regs_sva.sv
module tls_regs_sva
  import tls_pkg::*;
#(
  parameter int         POWERUP_COUNT = POWERUP_CYCLES,
  parameter logic [7:0] MAKER_CODE    = 8'h5A,
  parameter logic [7:0] REVISION_CODE = 8'h10
) (
  // Clocks and resets
  input wire logic         ref_clk,
  input wire logic         rst,
  input wire logic         linkClk,
  input wire logic         linkRst,
  // Register access
  input wire logic         regStrobe,
  input wire logic         regWrite,
  input wire logic [7:0]   regAddr,
  input wire logic [7:0]   regWrData,
  input wire logic         regBusy,
  input wire logic         regDone,
  input wire logic [7:0]   regRdData,
  // Conversion core and alarm pins
  input wire logic         tempValid,
  input wire logic [7:0]   remoteTemp,
  input wire logic [7:0]   localTemp,
  input wire logic         discreteDetect,
  input wire logic         diodeModeSelect,
  input wire tls_mask_type channelMask,
  input wire logic         criticalAlarmOutput_n,
  input wire logic         overtempShutdownOutput_n
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] capAddr_r;
  logic       capWrite_r;
  int         puCnt_r;

  // The request is remembered so that each answer can be judged by the address it answers.
  always_ff @(posedge linkClk) begin
    if (regStrobe && !regBusy) begin
      capAddr_r  <= regAddr;
      capWrite_r <= regWrite;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      puCnt_r <= 0;
    end else if (puCnt_r < POWERUP_COUNT) begin
      puCnt_r <= puCnt_r + 1;
    end
  end

  // ***************************************************************
  // Sequences
  // ***************************************************************
  sequence seqTake;
    regStrobe && !regBusy;
  endsequence

  sequence seqReadDone(logic [7:0] a);
    regDone && !capWrite_r && capAddr_r == a;
  endsequence

  // ***************************************************************
  // Assertions
  // ***************************************************************
  AST_DONE_BOUND: assert property (@(posedge linkClk) disable iff (linkRst)
    seqTake |-> ##[1:24] regDone) else $error("Register request not answered in time.");
  AST_BUSY_HOLD: assert property (@(posedge linkClk) disable iff (linkRst)
    seqTake |=> regBusy until regDone) else $error("Busy dropped before the answer.");
  AST_DONE_PULSE: assert property (@(posedge linkClk) disable iff (linkRst)
    regDone |-> !regBusy ##1 !regDone) else $error("Done is not a single idle pulse.");
  AST_STAT2_LOW: assert property (@(posedge linkClk) disable iff (linkRst)
    seqReadDone(ADDR_SECOND_STATUS) |-> regRdData[5:0] == 6'h00)
    else $error("Second status low bits not zero.");
  AST_HYST_TOP: assert property (@(posedge linkClk) disable iff (linkRst)
    seqReadDone(ADDR_HYSTERESIS) |-> regRdData[7:5] == 3'h0)
    else $error("Hysteresis upper bits not zero.");
  AST_MAKER: assert property (@(posedge linkClk) disable iff (linkRst)
    seqReadDone(ADDR_MAKER_ID) |-> regRdData == MAKER_CODE) else $error("Maker code wrong.");
  AST_REVISION: assert property (@(posedge linkClk) disable iff (linkRst)
    seqReadDone(ADDR_DIE_REVISION) |-> regRdData == REVISION_CODE)
    else $error("Revision code wrong.");
  AST_STAT1_RSVD: assert property (@(posedge linkClk) disable iff (linkRst)
    seqReadDone(ADDR_FIRST_STATUS) |-> (regRdData & 8'hEC) == 8'h00)
    else $error("First status unused bits set.");
  AST_PU_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
    puCnt_r < POWERUP_COUNT |-> criticalAlarmOutput_n && overtempShutdownOutput_n)
    else $error("Alarm pin active during power-up.");
  AST_MASK_QUIET: assert property (@(posedge ref_clk) disable iff (rst)
    (channelMask == 4'hF) [*3] |-> criticalAlarmOutput_n && overtempShutdownOutput_n)
    else $error("Alarm pin active with every channel masked.");
endmodule

bind tls_regs tls_regs_sva #(
  .POWERUP_COUNT(POWERUP_COUNT), .MAKER_CODE(MAKER_CODE), .REVISION_CODE(REVISION_CODE)
) chk (
  .ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .linkRst(linkRst),
  .regStrobe(regStrobe), .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData),
  .regBusy(regBusy), .regDone(regDone), .regRdData(regRdData), .tempValid(tempValid),
  .remoteTemp(remoteTemp), .localTemp(localTemp), .discreteDetect(discreteDetect),
  .diodeModeSelect(diodeModeSelect), .channelMask(channelMask),
  .criticalAlarmOutput_n(criticalAlarmOutput_n),
  .overtempShutdownOutput_n(overtempShutdownOutput_n)
);

// file: testbench/tls_host_model.sv
module tls_host_model
  import tls_pkg::*;
(
  // Link clock
  input  wire logic       linkClk,
  // Answer from the block
  input  wire logic       regBusy,
  input  wire logic       regDone,
  input  wire logic [7:0] regRdData,
  // Request to the block
  output logic            regStrobe,
  output logic            regWrite,
  output logic [7:0]      regAddr,
  output logic [7:0]      regWrData
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    regStrobe = 1'b0;
    regWrite  = 1'b0;
    regAddr   = 8'h00;
    regWrData = 8'h00;
  end

  // Released lines show the inverse of the last value, so a late sample never matches by luck.
  task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd,
                        input int gap, output logic [7:0] rd);
    int n;
    rd = 8'hXX;
    repeat (gap) @(negedge linkClk);
    @(negedge linkClk);
    regStrobe = 1'b1;
    regWrite  = wr;
    regAddr   = addr;
    regWrData = wd;
    @(posedge linkClk);
    @(negedge linkClk);
    regStrobe = 1'b0;
    regWrite  = ~wr;
    regAddr   = ~addr;
    regWrData = ~wd;
    for (n = 0; n < 40; n++) begin
      @(negedge linkClk);
      if (regDone === 1'b1) begin
        rd = regRdData;
        break;
      end
    end
  endtask
endmodule

// file: testbench/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tls_pkg::*;

  localparam int         PU    = 40;
  // Arbitrary identity values.
  localparam logic [7:0] MAKER = 8'h3C;
  localparam logic [7:0] REV   = 8'h07;

  logic         ref_clk, rst, linkClk, linkRst;
  logic         regStrobe, regWrite, regBusy, regDone, tempValid;
  logic [7:0]   regAddr, regWrData, regRdData, remoteTemp, localTemp;
  logic         discreteDetect, diodeModeSelect, critN, osN;
  tls_mask_type channelMask;
  int           errTotal = 0;
  int           numChecks = 0;

  tls_regs #(.POWERUP_COUNT(PU), .MAKER_CODE(MAKER), .REVISION_CODE(REV)) dut (
    .ref_clk(ref_clk), .rst(rst), .linkClk(linkClk), .linkRst(linkRst),
    .regStrobe(regStrobe), .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData),
    .regBusy(regBusy), .regDone(regDone), .regRdData(regRdData), .tempValid(tempValid),
    .remoteTemp(remoteTemp), .localTemp(localTemp), .discreteDetect(discreteDetect),
    .diodeModeSelect(diodeModeSelect), .channelMask(channelMask),
    .criticalAlarmOutput_n(critN), .overtempShutdownOutput_n(osN));

  tls_host_model host (
    .linkClk(linkClk), .regBusy(regBusy), .regDone(regDone), .regRdData(regRdData),
    .regStrobe(regStrobe), .regWrite(regWrite), .regAddr(regAddr), .regWrData(regWrData));

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial begin
    linkClk = 1'b0;
    #7;
    forever #16 linkClk = ~linkClk;
  end

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    host.access(1'b1, a, d, 2, dummy);
  endtask

  task automatic expect_rd(input string name, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.access(1'b0, a, 8'h00, 0, d);
    check(name, d, e);
  endtask

  // Pins follow one edge after the sample edge; the mask is applied with the sample.
  task automatic temp(input logic [7:0] r, input logic [7:0] l, input logic [7:0] st,
                      input logic [3:0] m);
    @(negedge ref_clk);
    channelMask = m;
    tempValid  = 1'b1;
    remoteTemp = r;
    localTemp  = l;
    @(negedge ref_clk);
    tempValid = 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    check("crit_pin", {7'h0, critN}, {7'h0, !((st[1] & !m[2]) | (st[0] & !m[0]))});
    check("os_pin", {7'h0, osN}, {7'h0, !((st[4] & !m[3]) | (st[0] & !m[1]))});
    expect_rd("stat1", ADDR_FIRST_STATUS, st);
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic t_powerup();
    expect_rd("stat2_busy", ADDR_SECOND_STATUS, 8'h80);
    temp(8'hFF, 8'hFF, 8'h00, 4'h0);
    repeat (PU) @(negedge ref_clk);
    expect_rd("stat2_ready", ADDR_SECOND_STATUS, 8'h00);
  endtask

  task automatic t_reset_values();
    expect_rd("ot_a", ADDR_REMOTE_OT_A, 8'h55);
    expect_rd("ot_b", ADDR_REMOTE_OT_B, 8'h55);
    expect_rd("crit", ADDR_REMOTE_CRIT, 8'h6E);
    expect_rd("local", ADDR_LOCAL_SHARED, 8'h55);
    expect_rd("hyst", ADDR_HYSTERESIS, 8'h0A);
    expect_rd("maker", ADDR_MAKER_ID, MAKER);
    expect_rd("rev", ADDR_DIE_REVISION, REV);
    expect_rd("unmapped", 8'h40, 8'h00);
  endtask

  task automatic t_writes();
    wr(ADDR_REMOTE_OT_A, 8'hA0);
    expect_rd("ot_pair_b", ADDR_REMOTE_OT_B, 8'hA0);
    wr(ADDR_REMOTE_OT_B, 8'h12);
    expect_rd("ot_pair_a", ADDR_REMOTE_OT_A, 8'h12);
    wr(ADDR_REMOTE_CRIT, 8'hFF);
    expect_rd("crit_rw", ADDR_REMOTE_CRIT, 8'hFF);
    wr(ADDR_LOCAL_SHARED, 8'h00);
    expect_rd("local_rw", ADDR_LOCAL_SHARED, 8'h00);
    wr(ADDR_HYSTERESIS, 8'hFF);
    expect_rd("hyst_rw", ADDR_HYSTERESIS, 8'h1F);
    wr(ADDR_MAKER_ID, 8'h00);
    wr(ADDR_DIE_REVISION, 8'h00);
    wr(ADDR_SECOND_STATUS, 8'hFF);
    expect_rd("maker_ro", ADDR_MAKER_ID, MAKER);
    expect_rd("rev_ro", ADDR_DIE_REVISION, REV);
    expect_rd("stat2_ro", ADDR_SECOND_STATUS, 8'h00);
  endtask

  task automatic t_detect();
    for (int i = 0; i < 4; i++) begin
      @(negedge ref_clk);
      discreteDetect  = i[1];
      diodeModeSelect = i[0];
      repeat (4) @(negedge ref_clk);
      expect_rd("stat2_detect", ADDR_SECOND_STATUS, {1'b0, i == 3, 6'h00});
    end
    discreteDetect  = 1'b0;
    diodeModeSelect = 1'b1;
  endtask

  task automatic t_limits();
    wr(ADDR_REMOTE_CRIT, 8'h80);
    wr(ADDR_REMOTE_OT_A, 8'h70);
    wr(ADDR_LOCAL_SHARED, 8'h60);
    wr(ADDR_HYSTERESIS, 8'h05);
    temp(8'h80, 8'h60, 8'h10, 4'h0);
    temp(8'h81, 8'h61, 8'h13, 4'h0);
    temp(8'h7B, 8'h5B, 8'h13, 4'h0);
    temp(8'h7A, 8'h5A, 8'h10, 4'h0);
    temp(8'h6A, 8'h5A, 8'h00, 4'h0);
  endtask

  task automatic t_mask();
    temp(8'hFF, 8'hFF, 8'h00, 4'hF);
    temp(8'hFF, 8'hFF, 8'h02, 4'hB);
    temp(8'h00, 8'h00, 8'h00, 4'h0);
  endtask

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    #200us;
    errTotal++;
    end_of_test();
  end

  initial begin
    rst             = 1'b1;
    linkRst         = 1'b1;
    tempValid       = 1'b0;
    remoteTemp      = 8'h00;
    localTemp       = 8'h00;
    discreteDetect  = 1'b0;
    diodeModeSelect = 1'b0;
    channelMask     = 4'h0;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    @(negedge linkClk);
    linkRst = 1'b0;
    repeat (5) @(negedge ref_clk);
    t_powerup();
    t_reset_values();
    t_writes();
    t_detect();
    t_limits();
    t_mask();
    end_of_test();
  end
endmodule
